//--- common/vic_consts.svh
// register offsets, field positions and reset values of the vectored interrupt controller
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH
`define VIC_ADDR_W         12
`define VIC_OFF_MODE_BASE  12'h000
`define VIC_OFF_MODE_LAST  12'h07C
`define VIC_OFF_VEC_BASE   12'h080
`define VIC_OFF_VEC_LAST   12'h0FC
`define VIC_OFF_IVR        12'h100
`define VIC_OFF_FVR        12'h104
`define VIC_OFF_CUR        12'h108
`define VIC_OFF_PEND       12'h10C
`define VIC_OFF_MASK       12'h110
`define VIC_OFF_CORE       12'h114
`define VIC_OFF_IEN        12'h120
`define VIC_OFF_IDIS       12'h124
`define VIC_OFF_ICLR       12'h128
`define VIC_OFF_ISET       12'h12C
`define VIC_OFF_EOI        12'h130
`define VIC_OFF_SPU        12'h134
`define VIC_OFF_DBG        12'h138
`define VIC_OFF_FFEN       12'h140
`define VIC_OFF_FFDIS      12'h144
`define VIC_OFF_FFST       12'h148
`define VIC_DBG_PROTECT_BIT_BIT   0
`define VIC_DBG_GENERAL_OUTPUT_MASK_BIT   1
`define VIC_PRIO_LSB       0
`define VIC_PRIO_MSB       2
`define VIC_TYPE_LSB       5
`define VIC_TYPE_MSB       6
`define VIC_MODE_RESET     7'h00
`define VIC_VEC_RESET      32'h0000_0000
`define VIC_NONE_PRIO      4'h0
`endif

//--- common/vic_pkg.sv
// shared types of the vectored interrupt controller
package vic_pkg;
   typedef logic [2:0] vic_prio_t;
   typedef logic [1:0] vic_type_t;
   typedef logic [4:0] vic_src_t;
endpackage

//--- src/vic_source.sv
// one interrupt source: edge/level detection and pending bit
`timescale 1ns/1ps
`default_nettype none
module vic_source #(
   parameter bit EXTERNAL = 1'b0
) (
   input  wire logic             ref_clk_in,
   input  wire logic             srst_in,
   input  wire logic             src_in,
   input  wire vic_pkg::vic_type_t type_in,
   input  wire logic             set_in,
   input  wire logic             clr_in,
   output logic                  pending_out
);
   logic sync1;
   logic sync2;
   logic prev;
   logic edge_reg;
   wire  edge_mode = type_in[0];
   wire  hi_active = EXTERNAL ? type_in[1] : 1'b1;
   wire  active    = hi_active ? sync2 : ~sync2;
   wire  prev_act  = hi_active ? prev : ~prev;
   wire  edge_hit  = active & ~prev_act;
   // reset value of the external line shows through the level path
   assign pending_out = edge_mode ? edge_reg : (active | edge_reg);

   // prev tracks the pin through reset, so no false edge follows release
   always_ff @(posedge ref_clk_in) begin
      sync1 <= src_in;
      sync2 <= sync1;
      prev  <= sync2;
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         edge_reg <= 1'b0;
      end else begin
         // set wins over clear
         if ((edge_mode & edge_hit) | set_in)
            edge_reg <= 1'b1;
         else if (clr_in)
            edge_reg <= 1'b0;
      end
   end
endmodule // vic_source
`default_nettype wire

//--- src/vic_prio_stack.sv
// priority stack: holds the current level and source per nesting depth
`timescale 1ns/1ps
`default_nettype none
module vic_prio_stack #(
   parameter int DEPTH = 8
) (
   input  wire logic              ref_clk_in,
   input  wire logic              srst_in,
   input  wire logic              push_in,
   input  wire logic              pop_in,
   input  wire vic_pkg::vic_prio_t push_prio_in,
   input  wire vic_pkg::vic_src_t  push_src_in,
   output logic                   active_out,
   output vic_pkg::vic_prio_t     top_prio_out,
   output vic_pkg::vic_src_t      top_src_out
);
   vic_pkg::vic_prio_t prio_mem [DEPTH];
   vic_pkg::vic_src_t  src_mem  [DEPTH];
   logic [3:0]         level;
   wire  [3:0]         top_idx = level - 4'h1;

   assign active_out   = (level != 4'h0);
   assign top_prio_out = active_out ? prio_mem[top_idx[2:0]] : 3'h0;
   assign top_src_out  = active_out ? src_mem[top_idx[2:0]] : 5'h00;

   // full stack drops further pushes; empty stack ignores pops
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         level <= 4'h0;
      end else if (push_in && level < 4'(DEPTH)) begin
         prio_mem[level[2:0]] <= push_prio_in;
         src_mem[level[2:0]]  <= push_src_in;
         level <= level + 4'h1;
      end else if (pop_in && active_out) begin
         level <= level - 4'h1;
      end
   end
endmodule // vic_prio_stack
`default_nettype wire

//--- src/vic_top.sv
// vectored interrupt controller: register file, arbitration, vector readout
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.svh"
module vic_top #(
   parameter int    NUM_SRC   = 32,
   parameter int    EXT_FIRST = 29,
   parameter int    STACK_D   = 8
) (
   input  wire logic        ref_clk_in,
   input  wire logic        srst_in,
   input  wire logic [11:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic [31:0] src_in,
   output logic             normal_request_n_out,
   output logic             fast_request_n_out,
   output logic             wake_out
);
   logic [6:0]  mode  [NUM_SRC];
   logic [31:0] vecs  [NUM_SRC];
   logic [31:0] spurious_vector;
   logic [1:0]  debug_control;
   logic [31:0] enable_mask;
   logic [31:0] ff_status;
   logic [31:0] pending;
   logic        rec_valid;
   logic [4:0]  rec_src;
   logic [2:0]  rec_prio;
   logic        protect_bit_armed;
   logic        stk_active;
   vic_pkg::vic_prio_t stk_prio;
   vic_pkg::vic_src_t  stk_src;
   logic        core_irq;
   logic        core_fiq;

   // address decode; only the low 12 bits reach us, giving a 4 KB window
   wire in_mode  = addr_in <= `VIC_OFF_MODE_LAST;
   wire in_vec   = addr_in >= `VIC_OFF_VEC_BASE && addr_in <= `VIC_OFF_VEC_LAST;
   wire [4:0] idx = addr_in[6:2];
   function automatic logic hit(input logic [11:0] off);
      return addr_in == off;
   endfunction
   wire wr_ivr   = wr_in & hit(`VIC_OFF_IVR);
   wire rd_ivr   = rd_in & hit(`VIC_OFF_IVR);
   wire rd_fvr   = rd_in & hit(`VIC_OFF_FVR);
   wire wr_eoi   = wr_in & hit(`VIC_OFF_EOI);
   wire wr_ien   = wr_in & hit(`VIC_OFF_IEN);
   wire wr_idis  = wr_in & hit(`VIC_OFF_IDIS);
   wire wr_iclr  = wr_in & hit(`VIC_OFF_ICLR);
   wire wr_iset  = wr_in & hit(`VIC_OFF_ISET);
   wire wr_ffen  = wr_in & hit(`VIC_OFF_FFEN);
   wire wr_ffdis = wr_in & hit(`VIC_OFF_FFDIS);
   wire protect_bit     = debug_control[`VIC_DBG_PROTECT_BIT_BIT];
   wire general_output_mask     = debug_control[`VIC_DBG_GENERAL_OUTPUT_MASK_BIT];

   // arbitration over enabled pending normal sources
   wire [31:0] live = pending & enable_mask;
   wire [31:0] norm_cand = live & ~ff_status & 32'hFFFF_FFFE;
   logic       best_valid;
   logic [4:0] best_src;
   logic [2:0] best_prio;
   always_comb begin
      best_valid = 1'b0;
      best_src   = 5'h00;
      best_prio  = 3'h0;
      // lower index wins a tie between equal priorities
      for (int i = NUM_SRC - 1; i >= 1; i--) begin
         if (norm_cand[i] &&
             (!best_valid || mode[i][`VIC_PRIO_MSB:`VIC_PRIO_LSB] >= best_prio)) begin
            best_valid = 1'b1;
            best_src   = 5'(i);
            best_prio  = mode[i][`VIC_PRIO_MSB:`VIC_PRIO_LSB];
         end
      end
   end
   wire above_cur = best_valid && (!stk_active || best_prio > stk_prio);
   wire fiq_live  = live[0] | |(live & ff_status);

   // each read computes afresh; in protect mode it only records the result
   wire        ivr_take   = rd_ivr & above_cur;
   wire [31:0] ivr_value  = above_cur ? vecs[best_src] : spurious_vector;
   wire        do_push    = protect_bit ? (wr_ivr & protect_bit_armed) : ivr_take;
   wire [4:0]  push_src   = protect_bit ? rec_src : best_src;
   wire [2:0]  push_prio  = protect_bit ? rec_prio : best_prio;
   // acknowledge clears an edge-triggered source when it is taken
   wire [31:0] ack_vec    = do_push ? (32'h1 << push_src) : 32'h0;
   wire        fiq_ack    = rd_fvr & ~ff_status[0] & mode[0][`VIC_TYPE_LSB];

   assign core_irq = above_cur;
   assign core_fiq = fiq_live;

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         wire clr_g = (wr_iclr & wdata_in[g]) |
                      (mode[g][`VIC_TYPE_LSB] & (ack_vec[g] | (g == 0 ? fiq_ack : 1'b0)));
         vic_source #(.EXTERNAL(g == 0 || g >= EXT_FIRST)) u_src (
            .ref_clk_in  (ref_clk_in),
            .srst_in     (srst_in),
            .src_in      (src_in[g]),
            .type_in     (mode[g][`VIC_TYPE_MSB:`VIC_TYPE_LSB]),
            .set_in      (wr_iset & wdata_in[g]),
            .clr_in      (clr_g),
            .pending_out (pending[g])
         );
      end
   endgenerate

   vic_prio_stack #(.DEPTH(STACK_D)) u_stack (
      .ref_clk_in   (ref_clk_in),
      .srst_in      (srst_in),
      .push_in      (do_push),
      .pop_in       (wr_eoi),
      .push_prio_in (push_prio),
      .push_src_in  (push_src),
      .active_out   (stk_active),
      .top_prio_out (stk_prio),
      .top_src_out  (stk_src)
   );

   // mode and vector register writes
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            mode[i] <= `VIC_MODE_RESET;
            vecs[i] <= `VIC_VEC_RESET;
         end
      end else if (wr_in && in_mode) begin
         mode[idx] <= {wdata_in[`VIC_TYPE_MSB:`VIC_TYPE_LSB], 2'b00,
                       wdata_in[`VIC_PRIO_MSB:`VIC_PRIO_LSB]};
      end else if (wr_in && in_vec) begin
         vecs[idx] <= wdata_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         spurious_vector <= `VIC_VEC_RESET;
         debug_control   <= 2'b00;
         enable_mask     <= 32'h0000_0000;
         ff_status       <= 32'h0000_0000;
      end else begin
         if (wr_in && hit(`VIC_OFF_SPU))
            spurious_vector <= wdata_in;
         if (wr_in && hit(`VIC_OFF_DBG))
            debug_control <= wdata_in[1:0];
         if (wr_ien)
            enable_mask <= enable_mask | wdata_in;
         else if (wr_idis)
            enable_mask <= enable_mask & ~wdata_in;
         if (wr_ffen)
            ff_status <= ff_status | (wdata_in & 32'hFFFF_FFFE);
         else if (wr_ffdis)
            ff_status <= ff_status & ~wdata_in;
      end
   end

   // record of the last protect-mode read, consumed by the vector write
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         protect_bit_armed <= 1'b0;
         rec_src    <= 5'h00;
         rec_prio   <= 3'h0;
      end else if (protect_bit && rd_ivr) begin
         protect_bit_armed <= above_cur;
         rec_src    <= best_src;
         rec_prio   <= best_prio;
      end else if (wr_ivr && protect_bit) begin
         protect_bit_armed <= 1'b0;
      end else if (!protect_bit) begin
         // a read left armed must not be replayed after a mode change
         protect_bit_armed <= 1'b0;
      end
   end

   // current source status follows the stack top, so it moves only on push/pop
   wire [31:0] cur_status = {27'h0, stk_src};
   wire [31:0] core_status = {30'h0, ~normal_request_n_out, ~fast_request_n_out};
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (in_mode)
         next_rdata = {25'h0, mode[idx]};
      else if (in_vec)
         next_rdata = vecs[idx];
      else begin
         case (addr_in)
            `VIC_OFF_IVR:  next_rdata = ivr_value;
            `VIC_OFF_FVR:  next_rdata = fiq_live ? vecs[0] : spurious_vector;
            `VIC_OFF_CUR:  next_rdata = cur_status;
            `VIC_OFF_PEND: next_rdata = pending;
            `VIC_OFF_MASK: next_rdata = enable_mask;
            `VIC_OFF_CORE: next_rdata = core_status;
            `VIC_OFF_SPU:  next_rdata = spurious_vector;
            `VIC_OFF_DBG:  next_rdata = {30'h0, debug_control};
            `VIC_OFF_FFST: next_rdata = ff_status;
            default:       next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         rdata_out            <= 32'h0000_0000;
         normal_request_n_out <= 1'b1;
         fast_request_n_out   <= 1'b1;
         wake_out             <= 1'b0;
      end else begin
         rdata_out            <= rd_in ? next_rdata : 32'h0000_0000;
         normal_request_n_out <= ~(core_irq & ~general_output_mask);
         fast_request_n_out   <= ~(core_fiq & ~general_output_mask);
         wake_out             <= core_irq | core_fiq;
      end
   end
endmodule // vic_top
`default_nettype wire

//--- sim/vic_top_asserts.sv
// port checker of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_top_asserts (
   input wire logic        ref_clk_in,
   input wire logic        srst_in,
   input wire logic [11:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        normal_request_n_out,
   input wire logic        fast_request_n_out,
   input wire logic        wake_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // shadows of plain read/write registers
   logic [1:0]  dbg_q;
   logic [31:0] spu_q;
   logic [31:0] vec0_q;
   wire         quiet = normal_request_n_out && fast_request_n_out;
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         dbg_q  <= 2'h0;
         spu_q  <= 32'h0;
         vec0_q <= 32'h0;
      end else if (wr_in) begin
         dbg_q  <= (addr_in == 12'h138) ? wdata_in[1:0] : dbg_q;
         spu_q  <= (addr_in == 12'h134) ? wdata_in : spu_q;
         vec0_q <= (addr_in == 12'h080) ? wdata_in : vec0_q;
      end
   end
   // lines are a registered stage behind the mask, so two cycles of margin
   general_output_mask_hold_a: assert property (
      dbg_q[1] && $past(dbg_q[1]) && $past(dbg_q[1], 2) |-> quiet)
      else $error("request active under general mask");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data outside answer cycle");
   reset_quiet_a: assert property (disable iff (1'b0)
      srst_in |=> quiet && !wake_out && rdata_out == 32'h0)
      else $error("outputs not idle in reset");
   unmapped_zero_a: assert property (
      rd_in && (addr_in == 12'h118 || addr_in == 12'h13C) |=> rdata_out == 32'h0)
      else $error("reserved read not zero");
   dbg_readback_a: assert property (
      rd_in && addr_in == 12'h138 |=> rdata_out == {30'h0, $past(dbg_q)})
      else $error("debug control readback wrong");
   spu_readback_a: assert property (
      rd_in && addr_in == 12'h134 |=> rdata_out == $past(spu_q))
      else $error("spurious vector readback wrong");
   vec0_readback_a: assert property (
      rd_in && addr_in == 12'h080 |=> rdata_out == $past(vec0_q))
      else $error("source vector readback wrong");
   release_quiet_a: assert property ($fell(srst_in) |-> quiet)
      else $error("request at reset release");
   cover property (rd_in && addr_in == 12'h100);
   cover property (wr_in && addr_in == 12'h130);
   cover property (dbg_q[1] && wake_out);
endmodule // vic_top_asserts
bind vic_top vic_top_asserts u_vic_top_asserts (.ref_clk_in, .srst_in, .addr_in,
   .wdata_in, .wr_in, .rd_in, .rdata_out, .normal_request_n_out,
   .fast_request_n_out, .wake_out);
`default_nettype wire

//--- sim/vic_core_model.sv
// processor core stand-in: takes request lines, wakes from idle
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
   input  wire logic ref_clk_in,
   input  wire logic srst_in,
   input  wire logic normal_request_n_in,
   input  wire logic fast_request_n_in,
   input  wire logic wake_in,
   output logic      woke_out,
   output logic      taken_out
);
   // sticky, so a short wake event is not lost
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) woke_out <= 1'b0;
      else if (wake_in) woke_out <= 1'b1;
   end
   // never halted between vector read and write
   assign taken_out = !normal_request_n_in || !fast_request_n_in;
endmodule // vic_core_model
`default_nettype wire

//--- sim/vic_top_tb.sv
// self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_top_tb;
   logic        ref_clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   // bit 31 external low-level: pending straight out of reset
   logic [31:0] src = 32'h6000_0001;
   logic [31:0] rdata, v5, spu;
   logic        normal_n, fast_n, wake, woke;
   logic [31:0] mdl [int];
   int          sel [3] = '{0, 1, 31};
   int          fails = 0;
   int          total_checks = 0;
   vic_top u_vic_top (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .src_in(src),
      .normal_request_n_out(normal_n), .fast_request_n_out(fast_n), .wake_out(wake));
   vic_core_model u_vic_core_model (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .normal_request_n_in(normal_n),
      .fast_request_n_in(fast_n), .wake_in(wake), .woke_out(woke), .taken_out());
   initial begin
      forever #10 ref_clk_in = ~ref_clk_in;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_in);
      wr <= 1'b0;
      // mode registers keep type and priority only
      mdl[a] = (a < 12'h080) ? (d & 32'h0000_0067) : d;
      #1;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
      @(posedge ref_clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wait_normal(input logic lvl);
      int n;
      for (n = 0; n < 40 && normal_n !== lvl; n++) idle(1);
      chk(normal_n, lvl);
      if (n == 40) close_out;
   endtask
   task automatic wait_fast(input logic lvl);
      int n;
      for (n = 0; n < 40 && fast_n !== lvl; n++) idle(1);
      chk(fast_n, lvl);
      if (n == 40) close_out;
   endtask
   initial begin
      void'($urandom(32'h3D16));
      repeat (3) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      idle(3);
      rd_reg(12'h10C, 32'h8000_0000);
      rd_reg(12'h108, 32'h0);
      rd_reg(12'h118, 32'h0);
      $display("test reset done");
      foreach (sel[k]) begin
         wr_reg(12'(sel[k] * 4), $urandom);
         wr_reg(12'(sel[k] * 4 + 128), $urandom);
         rd_reg(12'(sel[k] * 4), mdl[sel[k] * 4]);
         rd_reg(12'(sel[k] * 4 + 128), mdl[sel[k] * 4 + 128]);
      end
      wr_reg(12'h138, 32'hFFFF_FFFF);
      rd_reg(12'h138, 32'h0000_0003);
      wr_reg(12'h138, 32'h0);
      wr_reg(12'h000, 32'h0);
      $display("test registers done");
      spu = $urandom;
      wr_reg(12'h134, spu);
      rd_reg(12'h100, spu);
      wr_reg(12'h130, 32'h0);
      rd_reg(12'h104, spu);
      $display("test spurious done");
      v5 = $urandom;
      wr_reg(12'h014, 32'h0000_0003);
      wr_reg(12'h094, v5);
      wr_reg(12'h120, 32'h0000_0020);
      @(posedge ref_clk_in);
      src[5] <= 1'b1;
      wait_normal(1'b0);
      rd_reg(12'h100, v5);
      rd_reg(12'h108, 32'h5);
      wait_normal(1'b1);
      wr_reg(12'h100, 32'h0);
      idle(2);
      chk(normal_n, 1'b1);
      wr_reg(12'h130, 32'hFFFF_FFFF);
      wait_normal(1'b0);
      $display("test normal done");
      wr_reg(12'h138, 32'h1);
      rd_reg(12'h100, v5);
      rd_reg(12'h100, v5);
      idle(2);
      chk(normal_n, 1'b0);
      rd_reg(12'h108, 32'h0);
      wr_reg(12'h100, 32'h0);
      wait_normal(1'b1);
      rd_reg(12'h108, 32'h5);
      wr_reg(12'h130, 32'h0);
      wr_reg(12'h138, 32'h0);
      wait_normal(1'b0);
      $display("test protect done");
      // source 0 is external low-level at mode zero; pulling its pin low raises it
      wr_reg(12'h120, 32'h0000_0001);
      @(posedge ref_clk_in);
      src[0] <= 1'b0;
      wait_fast(1'b0);
      rd_reg(12'h104, mdl[128]);
      rd_reg(12'h114, 32'h0000_0003);
      $display("test fast done");
      wr_reg(12'h138, 32'h2);
      idle(3);
      chk(normal_n, 1'b1);
      chk(fast_n, 1'b1);
      chk(wake, 1'b1);
      chk(woke, 1'b1);
      $display("test mask done");
      close_out;
   end
endmodule // vic_top_tb
`default_nettype wire
